// ### bench/asrc_ctrl_chk.sv
`timescale 1ns/100ps
module asrc_ctrl_chk
  import asrc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              select_low_active_b,
  input wire logic              select_high_active,
  input wire logic              write_strobe_b,
  input wire logic              output_gate_b,
  input wire logic [DATA_W-1:0] byte_lines_o,
  input wire logic              byte_lines_oe
);
  // ========
  // pin timing at 4 ns per cycle
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire sel_on = !select_low_active_b && select_high_active;
  sequence s_wr_pulse;
    !write_strobe_b [*3] ##1 write_strobe_b;
  endsequence
  sequence s_rd_gate;
    !output_gate_b [*4] ##1 output_gate_b ##0 rsp_valid;
  endsequence
  a_sel_pair: assert property (
    select_low_active_b != select_high_active) else $error("selects split");
  a_wr_sel: assert property (
    !write_strobe_b |-> sel_on && output_gate_b) else $error("bad write");
  a_wr_pulse: assert property (
    $fell(write_strobe_b) |-> s_wr_pulse) else $error("strobe width");
  a_data_setup: assert property ($rose(write_strobe_b) |->
    $past(sel_on, 3) && $past(byte_lines_oe, 2)
    && $past(byte_lines_o) == $past(byte_lines_o, 2)) else $error("setup");
  a_addr_hold: assert property (
    !write_strobe_b || $rose(write_strobe_b) |-> $stable(mem_addr))
    else $error("write addr moved");
  a_drive_safe: assert property (
    byte_lines_oe |-> output_gate_b && !write_strobe_b) else $error("fight");
  a_rd_gate: assert property (
    $fell(output_gate_b) |-> sel_on && write_strobe_b ##0 s_rd_gate)
    else $error("gate window");
  a_rsp_time: assert property (
    $fell(output_gate_b) |-> ##4 rsp_valid ##1 !rsp_valid)
    else $error("rsp timing");
  a_addr_first: assert property (
    !select_low_active_b && !$fell(select_low_active_b) |-> $stable(mem_addr))
    else $error("addr after select");
endmodule
bind asrc_ctrl asrc_ctrl_chk asrc_ctrl_chk_inst (.core_clk, .rst_b,
  .rsp_valid, .mem_addr, .select_low_active_b, .select_high_active,
  .write_strobe_b, .output_gate_b, .byte_lines_o, .byte_lines_oe);

// ### bench/asrc_mem_model.sv
`timescale 1ns/100ps
module asrc_mem_model
  import asrc_pkg::*;
#(
  parameter int RD_DLY = 5
)(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              sel_b,
  input wire logic              sel,
  input wire logic              we_b,
  input wire logic              oe_b,
  input wire logic [DATA_W-1:0] din,
  output logic     [DATA_W-1:0] dout,
  output logic                  drv
);
  // ========
  // behavioural byte array
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              we_ok;
  wire act = !sel_b && sel;
  assign #3 we_ok = we_b;
  assign drv = act && we_b && we_ok && !oe_b;
  // inertial delay keeps old byte a while: slow but within access time
  assign #RD_DLY dout = mem[addr];
  always @(posedge we_b) if (act) mem[addr] = din;
  always @(posedge sel_b or negedge sel) if (!we_b) mem[addr] = din;
endmodule

// ### bench/async_sram_128k_x8_tb.sv
`timescale 1ns/100ps
module async_sram_128k_x8_tb;
  import asrc_pkg::*;
  logic              core_clk, rst_b, req, req_write, req_ready, rsp_valid;
  logic              select_low_active_b, select_high_active, drv;
  logic              write_strobe_b, output_gate_b, byte_lines_oe;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [ADDR_W-1:0] a [12];
  logic [DATA_W-1:0] req_wdata, rsp_rdata, byte_lines_o, bl, dout;
  logic [DATA_W-1:0] junk = 8'hC6;
  logic [DATA_W-1:0] ref_mem [int];
  int                bad_count, n_tests;
  // released bus shows a changing pattern, never a held value
  assign #1 bl = byte_lines_oe ? byte_lines_o : drv ? dout : junk;
  always @(posedge core_clk) junk <= junk + 8'h3B;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  asrc_ctrl asrc_ctrl_inst (.core_clk, .rst_b, .req, .req_write, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
    .select_low_active_b, .select_high_active, .write_strobe_b,
    .output_gate_b, .byte_lines_i(bl), .byte_lines_o, .byte_lines_oe);
  asrc_mem_model asrc_mem_model_inst (.addr(mem_addr),
    .sel_b(select_low_active_b), .sel(select_high_active),
    .we_b(write_strobe_b), .oe_b(output_gate_b), .din(bl), .dout, .drv);
  task automatic chk(input string nm, input logic [7:0] e, s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic op(input logic w, input logic [ADDR_W-1:0] ad,
                    input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    // one edge between calls, so req is never lowered and raised at once
    @(posedge core_clk);
    #1;
    req = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    while (req_ready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("ready", 8'h01, {7'h00, req_ready});
    @(posedge core_clk);
    #1;
    req = 1'b0;
    if (w) ref_mem[ad] = d;
    else begin
      k = 0;
      do begin
        @(posedge core_clk);
        #1;
        k++;
      end while (rsp_valid !== 1'b1 && k < 9);
      chk("latency", 8'(RD_CYC), 8'(k));
      chk("rdata", ref_mem[ad], rsp_rdata);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #10000;
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_b, req, req_write, req_addr, req_wdata} = '0;
    void'($urandom(84320));
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset_sel", 8'h01, {7'h00, select_low_active_b});
    rst_b = 1'b1;
    // ========
    // corner addresses first, back-to-back requests refused until ready
    for (int i = 0; i < 12; i++) begin
      a[i] = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'($urandom);
      op(1'b1, a[i], 8'($urandom));
    end
    for (int i = 11; i >= 0; i--) op(1'b0, a[i], 8'h00);
    $display("test fill and readback done");
    for (int i = 0; i < 20; i++) op(1'($urandom), a[$urandom % 12],
                                    8'($urandom));
    $display("test mixed traffic done");
    finish_test();
  end
endmodule

// ### logic/asrc_count.sv
`timescale 1ns/100ps
module asrc_count
  import asrc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q;

  // ==========================================================
  // down counter, done when zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign done = (cnt_q == '0);

endmodule

// ### logic/asrc_ctrl.sv
`timescale 1ns/100ps
module asrc_ctrl
  import asrc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // user side
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // memory pins
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   select_low_active_b,
  output logic                   select_high_active,
  output logic                   write_strobe_b,
  output logic                   output_gate_b,
  input  wire logic [DATA_W-1:0] byte_lines_i,
  output logic [DATA_W-1:0]      byte_lines_o,
  output logic                   byte_lines_oe
);

  asrc_state_t      state_q;
  asrc_state_t      state_d;
  logic             load;
  logic [CNT_W-1:0] load_val;
  logic             done;
  logic             accept;

  asrc_count u_count (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .load     (load),
    .value    (load_val),
    .done     (done)
  );

  assign accept = req_ready && req;

  // ==========================================================
  // sequencer
  always_comb begin
    state_d  = state_q;
    load     = 1'b0;
    load_val = '0;
    unique case (state_q)
      ASRC_IDLE: begin
        if (accept && !req_write) begin
          state_d  = ASRC_READ;
          load     = 1'b1;
          load_val = CNT_W'(RD_CYC - 1);
        end else if (accept) begin
          state_d  = ASRC_TURN;
          load     = 1'b1;
          load_val = CNT_W'(TURN_CYC - 1);
        end
      end
      ASRC_READ: begin
        if (done) begin
          state_d  = ASRC_REC;
          load     = 1'b1;
          load_val = CNT_W'(TURN_CYC - 1);
        end
      end
      ASRC_TURN: begin
        if (done) begin
          state_d  = ASRC_WRITE;
          load     = 1'b1;
          load_val = CNT_W'(WR_CYC - 1);
        end
      end
      ASRC_WRITE: begin
        if (done) begin
          state_d  = ASRC_REC;
          load     = 1'b1;
          load_val = CNT_W'(REC_CYC - 1);
        end
      end
      ASRC_REC: begin
        if (done) begin
          state_d = ASRC_IDLE;
        end
      end
      // unused codes of the 3-bit state fall back to idle
      default: begin
        state_d = ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= ASRC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // handshake
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_d == ASRC_IDLE) && !accept;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RST;
    end else begin
      rsp_valid <= 1'b0;
      // sampled while gate still low, before any address change
      if (state_q == ASRC_READ && done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= byte_lines_i;
      end
    end
  end

  // ==========================================================
  // pins; address and selects set in the same edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_addr <= ADDR_RST;
    end else if (accept) begin
      mem_addr <= req_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      select_low_active_b <= 1'b1;
      select_high_active  <= 1'b0;
    end else begin
      select_low_active_b <= (state_d == ASRC_IDLE);
      select_high_active  <= (state_d != ASRC_IDLE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      output_gate_b  <= 1'b1;
      write_strobe_b <= 1'b1;
    end else begin
      // gate only low in read, so writes never see a driving memory
      output_gate_b  <= (state_d != ASRC_READ);
      // strobe rising ends the write ahead of the selects
      write_strobe_b <= (state_d != ASRC_WRITE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      byte_lines_o  <= DATA_RST;
      byte_lines_oe <= 1'b0;
    end else begin
      if (accept && req_write) begin
        byte_lines_o <= req_wdata;
      end
      // drive only after the turnaround, dropped on the same edge as the strobe rise
      byte_lines_oe <= (state_d == ASRC_WRITE);
    end
  end

endmodule

// ### logic/asrc_pkg.sv
package asrc_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // timing, ps and derived cycles at 4 ns
  localparam int unsigned CLK_PS      = 4000;
  localparam int unsigned T_CYCLE_PS  = 12000;
  localparam int unsigned T_AA_PS     = 12000;
  localparam int unsigned T_OE_PS     = 6000;
  localparam int unsigned T_OHZ_PS    = 5000;
  localparam int unsigned T_CW_PS     = 10000;
  localparam int unsigned T_AW_PS     = 10000;
  localparam int unsigned T_WP_PS     = 8000;
  localparam int unsigned T_DW_PS     = 7000;
  localparam int unsigned T_WZ_PS     = 5000;
  localparam int unsigned T_OW_PS     = 3000;

  function automatic int unsigned cyc_up(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // read: wait access time plus one sample cycle
  localparam int unsigned RD_CYC  = cyc_up(T_AA_PS) + 1;
  // gate release before the controller may drive
  localparam int unsigned TURN_CYC =
    cyc_up((T_OHZ_PS > T_WZ_PS) ? T_OHZ_PS : T_WZ_PS);
  // strobe low width, covers select, address and data setup
  localparam int unsigned WR_CYC  =
    cyc_up((T_CW_PS > T_WP_PS) ? T_CW_PS : T_WP_PS);
  localparam int unsigned REC_CYC = cyc_up(T_OW_PS);
  localparam int unsigned CYC_MIN = cyc_up(T_CYCLE_PS);
  localparam int unsigned CNT_W   = 4;

  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;

  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_READ, ASRC_TURN, ASRC_WRITE, ASRC_REC
  } asrc_state_t;

endpackage
